// File: verilog/gur_register_map.sv
`timescale 1ns/1ns
module gur_register_map #(
    parameter logic [15:0] PRODUCT_CODE = 16'h1234 // Arbitrary value
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    // Sensor core results
    input wire logic i_sample_valid,
    input wire logic [11:0] i_supply,
    input wire logic [13:0] i_rate,
    input wire logic [11:0] i_aux,
    input wire logic [11:0] i_temp,
    input wire logic i_angle_incr,
    input wire logic [15:0] i_diag_flags,
    // Nonvolatile store read port
    output logic o_nv_rd,
    output logic [5:0] o_nv_addr,
    input wire logic [15:0] i_nv_data,
    // Status and command pulses
    output logic o_ready,
    output logic [7:0] o_command,
    // Configuration to the sensor core
    output logic [15:0] o_rate_offset_trim,
    output logic [15:0] o_rate_scale_trim,
    output logic [15:0] o_alarm_one_magnitude,
    output logic [15:0] o_alarm_two_magnitude,
    output logic [15:0] o_alarm_one_rate_window,
    output logic [15:0] o_alarm_two_rate_window,
    output logic [15:0] o_alarm_control,
    output logic [15:0] o_analog_out_setting,
    output logic [15:0] o_digital_line_control,
    output logic [15:0] o_misc_control,
    output logic [15:0] o_sample_period,
    output logic [15:0] o_range_and_filter,
    output logic [15:0] o_sleep_counter
);
    localparam int NW = gur_pkg::NUM_WORDS;
    localparam logic [5:0] IDX_FLASH_WRITE_COUNT = gur_pkg::OFS_FLASH_WRITE_COUNT[6:1];
    localparam logic [5:0] IDX_SUPPLY = gur_pkg::OFS_SUPPLY[6:1];
    localparam logic [5:0] IDX_RATE = gur_pkg::OFS_RATE[6:1];
    localparam logic [5:0] IDX_AUX = gur_pkg::OFS_AUX[6:1];
    localparam logic [5:0] IDX_TEMP = gur_pkg::OFS_TEMP[6:1];
    localparam logic [5:0] IDX_ANGLE = gur_pkg::OFS_ANGLE[6:1];
    localparam logic [5:0] IDX_OFFSET = gur_pkg::OFS_OFFSET[6:1];
    localparam logic [5:0] IDX_SCALE = gur_pkg::OFS_SCALE[6:1];
    localparam logic [5:0] IDX_ALM1_MAG = gur_pkg::OFS_ALM1_MAG[6:1];
    localparam logic [5:0] IDX_ALM2_MAG = gur_pkg::OFS_ALM2_MAG[6:1];
    localparam logic [5:0] IDX_ALM1_WIN = gur_pkg::OFS_ALM1_WIN[6:1];
    localparam logic [5:0] IDX_ALM2_WIN = gur_pkg::OFS_ALM2_WIN[6:1];
    localparam logic [5:0] IDX_ALARM_CONTROL = gur_pkg::OFS_ALARM_CONTROL[6:1];
    localparam logic [5:0] IDX_DAC = gur_pkg::OFS_DAC[6:1];
    localparam logic [5:0] IDX_GPIO = gur_pkg::OFS_GPIO[6:1];
    localparam logic [5:0] IDX_MISC = gur_pkg::OFS_MISC[6:1];
    localparam logic [5:0] IDX_SMPL = gur_pkg::OFS_SMPL[6:1];
    localparam logic [5:0] IDX_RANGE = gur_pkg::OFS_RANGE[6:1];
    localparam logic [5:0] IDX_SLEEP = gur_pkg::OFS_SLEEP[6:1];
    localparam logic [5:0] IDX_DIAG = gur_pkg::OFS_DIAG[6:1];
    localparam logic [5:0] IDX_CMD = gur_pkg::OFS_CMD[6:1];
    localparam logic [5:0] IDX_LOT1 = gur_pkg::OFS_LOT1[6:1];
    localparam logic [5:0] IDX_LOT2 = gur_pkg::OFS_LOT2[6:1];
    localparam logic [5:0] IDX_PROD = gur_pkg::OFS_PROD[6:1];
    localparam logic [5:0] IDX_SERIAL = gur_pkg::OFS_SERIAL[6:1];
    localparam logic [5:0] IDX_LAST = 6'(NW - 1);

    typedef struct packed {
        gur_pkg::gur_state_t st;
        logic [5:0] ld_idx;
        logic [1:0] ld_wait;
        logic [NW-1:0][15:0] regs;
        logic [NW-1:0] fresh;
        logic [15:0] tx_word;
        logic [7:0] command;
        logic nv_rd;
        logic [5:0] nv_addr;
        logic ready;
    } gur_bank_t;

    gur_bank_t q;
    gur_bank_t next_q;
    logic frame_valid;
    logic [15:0] frame;

    // Word decoding shared by load, write and read paths
    function automatic logic word_is_mapped(input logic [5:0] idx);
        case (idx)
            IDX_FLASH_WRITE_COUNT, IDX_SUPPLY, IDX_RATE, IDX_AUX, IDX_TEMP, IDX_ANGLE,
            IDX_OFFSET, IDX_SCALE, IDX_ALM1_MAG, IDX_ALM2_MAG, IDX_ALM1_WIN,
            IDX_ALM2_WIN, IDX_ALARM_CONTROL, IDX_DAC, IDX_GPIO, IDX_MISC, IDX_SMPL,
            IDX_RANGE, IDX_SLEEP, IDX_DIAG, IDX_CMD, IDX_LOT1, IDX_LOT2,
            IDX_PROD, IDX_SERIAL: word_is_mapped = 1'b1;
            default: word_is_mapped = 1'b0; // RL1
        endcase
    endfunction

    function automatic logic word_is_writable(input logic [5:0] idx);
        case (idx)
            IDX_ANGLE, IDX_OFFSET, IDX_SCALE, IDX_ALM1_MAG, IDX_ALM2_MAG,
            IDX_ALM1_WIN, IDX_ALM2_WIN, IDX_ALARM_CONTROL, IDX_DAC, IDX_GPIO,
            IDX_MISC, IDX_SMPL, IDX_RANGE, IDX_SLEEP, IDX_CMD: word_is_writable = 1'b1;
            default: word_is_writable = 1'b0;
        endcase
    endfunction

    function automatic logic word_is_nv(input logic [5:0] idx);
        case (idx)
            IDX_FLASH_WRITE_COUNT, IDX_OFFSET, IDX_SCALE, IDX_ALM1_MAG, IDX_ALM2_MAG,
            IDX_ALM1_WIN, IDX_ALM2_WIN, IDX_ALARM_CONTROL, IDX_MISC, IDX_SMPL,
            IDX_RANGE, IDX_SLEEP, IDX_LOT1, IDX_LOT2, IDX_SERIAL: word_is_nv = 1'b1; // RL11 RL12 RL16 RL17
            default: word_is_nv = 1'b0; // RL15
        endcase
    endfunction

    function automatic logic word_is_output(input logic [5:0] idx);
        case (idx)
            IDX_SUPPLY, IDX_RATE, IDX_AUX, IDX_TEMP, IDX_ANGLE: word_is_output = 1'b1;
            default: word_is_output = 1'b0;
        endcase
    endfunction

    // Values for volatile words; backed words come from the store
    function automatic logic [15:0] word_reset(input logic [5:0] idx);
        case (idx)
            IDX_SCALE: word_reset = gur_pkg::RST_SCALE;
            IDX_SMPL: word_reset = gur_pkg::RST_SMPL; // RL13
            IDX_RANGE: word_reset = gur_pkg::RST_RANGE; // RL14
            IDX_PROD: word_reset = PRODUCT_CODE;
            default: word_reset = gur_pkg::RST_ZERO; // RL15
        endcase
    endfunction

    // Narrower ranges weigh each code more; no saturation on overflow
    function automatic logic [13:0] scale_rate(input logic [13:0] raw, input logic [2:0] range);
        case (range)
            gur_pkg::RANGE_160: scale_rate = {raw[12:0], 1'b0};
            gur_pkg::RANGE_80: scale_rate = {raw[11:0], 2'b00};
            default: scale_rate = raw;
        endcase
    endfunction

    gur_spi_slave u_spi (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .i_tx_word(q.tx_word),
        .o_frame_valid(frame_valid),
        .o_frame(frame)
    );

    // Load sequence, frame decode and sample capture
    always_comb begin
        logic [6:0] f_addr;
        logic [5:0] f_idx;
        logic [7:0] f_data;
        logic f_write;
        logic alarm;
        f_addr = frame[gur_pkg::FRAME_ADDR_LSB +: gur_pkg::ADDR_W];
        f_idx = f_addr[6:1]; // RL2
        f_data = frame[7:0];
        f_write = frame[gur_pkg::FRAME_WRITE_BIT];
        alarm = |q.regs[IDX_DIAG]; // RL4
        next_q = q;
        next_q.command = '0;
        next_q.nv_rd = 1'b0;
        next_q.regs[IDX_DIAG] = i_diag_flags;
        case (q.st)
            gur_pkg::ST_LOAD: begin
                // Walk every word, fetching backed ones from the store
                if (q.ld_wait == 2'h0) begin
                    if (word_is_nv(q.ld_idx)) begin
                        next_q.nv_addr = q.ld_idx; // RL18
                        next_q.nv_rd = 1'b1;
                        next_q.ld_wait = gur_pkg::NV_LATENCY;
                    end else begin
                        if (q.ld_idx != IDX_DIAG) begin
                            next_q.regs[q.ld_idx] = word_reset(q.ld_idx);
                        end
                        next_q.ld_idx = q.ld_idx + 6'h01;
                    end
                end else begin
                    next_q.ld_wait = q.ld_wait - 2'h1;
                    if (q.ld_wait == 2'h1) begin
                        next_q.regs[q.nv_addr] = i_nv_data; // RL18
                        next_q.ld_idx = q.ld_idx + 6'h01;
                    end
                end
                // Data only flows once every word holds its value
                if (q.ld_idx == IDX_LAST && next_q.ld_idx != q.ld_idx) begin
                    next_q.st = gur_pkg::ST_RUN; // RL18
                    next_q.ready = 1'b1;
                end
            end
            gur_pkg::ST_RUN: begin
                // Angle counts in a 0..9827 circle
                if (i_angle_incr) begin
                    if (q.regs[IDX_ANGLE][13:0] == gur_pkg::ANGLE_MAX) begin
                        next_q.regs[IDX_ANGLE] = gur_pkg::RST_ZERO; // RL8
                    end else begin
                        next_q.regs[IDX_ANGLE] = q.regs[IDX_ANGLE] + 16'h0001; // RL8
                    end
                end
                if (frame_valid && f_write) begin
                    // One byte per frame; the odd address is the upper byte
                    if (word_is_mapped(f_idx) && word_is_writable(f_idx)) begin // RL20 RL22
                        if (f_idx == IDX_CMD) begin
                            next_q.command = f_data;
                            if (f_data[gur_pkg::CMD_FLASH_UPDATE]) begin
                                next_q.regs[IDX_FLASH_WRITE_COUNT] = q.regs[IDX_FLASH_WRITE_COUNT] + 16'h0001; // RL11
                            end
                            if (f_data[gur_pkg::CMD_SW_RESET]) begin
                                next_q.st = gur_pkg::ST_LOAD;
                                next_q.ld_idx = '0;
                                next_q.ld_wait = '0;
                                next_q.ready = 1'b0;
                                next_q.tx_word = '0;
                            end
                        end else if (f_addr[0]) begin
                            next_q.regs[f_idx][15:8] = f_data; // RL2
                        end else begin
                            next_q.regs[f_idx][7:0] = f_data; // RL2
                        end
                        if (f_idx == IDX_ANGLE) begin
                            next_q.regs[IDX_ANGLE][15:gur_pkg::FIELD_W] = 2'b00;
                        end
                    end
                end else if (frame_valid) begin
                    // Answer goes out in the next frame
                    if (!word_is_mapped(f_idx) || f_idx == IDX_CMD) begin
                        next_q.tx_word = '0; // RL22
                    end else if (word_is_output(f_idx)) begin
                        next_q.tx_word = {q.fresh[f_idx], alarm, q.regs[f_idx][13:0]}; // RL21 RL3 RL4
                        next_q.fresh[f_idx] = 1'b0; // RL21
                    end else begin
                        next_q.tx_word = q.regs[f_idx]; // RL19
                    end
                end
                // New samples last so a same-cycle read cannot lose the flag
                if (i_sample_valid) begin
                    next_q.regs[IDX_SUPPLY] = {4'h0, i_supply}; // RL5
                    next_q.regs[IDX_RATE] = {2'b00, scale_rate(i_rate, q.regs[IDX_RANGE][gur_pkg::RANGE_LSB +: 3])}; // RL6 RL7
                    next_q.regs[IDX_AUX] = {4'h0, i_aux}; // RL10
                    next_q.regs[IDX_TEMP] = {4'h0, i_temp}; // RL9
                    next_q.fresh[IDX_SUPPLY] = 1'b1; // RL3
                    next_q.fresh[IDX_RATE] = 1'b1; // RL3
                    next_q.fresh[IDX_AUX] = 1'b1; // RL3
                    next_q.fresh[IDX_TEMP] = 1'b1; // RL3
                end
                if (i_angle_incr) begin
                    next_q.fresh[IDX_ANGLE] = 1'b1; // RL3
                end
            end
            default: begin
                next_q.st = gur_pkg::ST_LOAD;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Outputs taken straight from the state flops
    assign o_nv_rd = q.nv_rd;
    assign o_nv_addr = q.nv_addr;
    assign o_ready = q.ready;
    assign o_command = q.command;
    assign o_rate_offset_trim = q.regs[IDX_OFFSET];
    assign o_rate_scale_trim = q.regs[IDX_SCALE];
    assign o_alarm_one_magnitude = q.regs[IDX_ALM1_MAG];
    assign o_alarm_two_magnitude = q.regs[IDX_ALM2_MAG];
    assign o_alarm_one_rate_window = q.regs[IDX_ALM1_WIN];
    assign o_alarm_two_rate_window = q.regs[IDX_ALM2_WIN];
    assign o_alarm_control = q.regs[IDX_ALARM_CONTROL];
    assign o_analog_out_setting = q.regs[IDX_DAC];
    assign o_digital_line_control = q.regs[IDX_GPIO];
    assign o_misc_control = q.regs[IDX_MISC];
    assign o_sample_period = q.regs[IDX_SMPL];
    assign o_range_and_filter = q.regs[IDX_RANGE];
    assign o_sleep_counter = q.regs[IDX_SLEEP];
endmodule

// File: verilog/gur_pkg.sv
// Behaviour
// RL1 - Unlisted addresses are reserved, no behaviour
// RL2 - Register spans address and address plus one
// RL3 - New-data flag set while value unread
// RL4 - Error flag mirrors any diagnostic flag set
// RL5 - Supply word is 12-bit unsigned
// RL6 - Rate word is 14-bit two's complement
// RL7 - Rate weight follows selected measurement range
// RL8 - Angle word 14-bit, wraps past 9827
// RL9 - Temperature word 12-bit two's complement
// RL10 - Auxiliary input word is 12-bit unsigned
// RL11 - Flash write count read-only, kept nonvolatile
// RL12 - Five alarm words, read/write, nonvolatile, zero
// RL13 - Sample period defaults 0x0001, nonvolatile
// RL14 - Range/filter defaults 0x0402, nonvolatile
// RL15 - Analog output setting zero, volatile
// RL16 - Misc control defaults zero, nonvolatile
// RL17 - Sleep counter defaults zero, nonvolatile
// RL18 - Reset reloads nonvolatile words before data
// RL19 - Read answers in the following frame
// RL20 - Host writes one byte per frame
// RL21 - Flags in bits 15/14, read clears new-data
// RL22 - Bad writes ignored, bad reads return zero
package gur_pkg;
    // Geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int IDX_W = 6;
    localparam int NUM_WORDS = 45;
    localparam int FRAME_W = 16;
    localparam int FRAME_WRITE_BIT = 15;
    localparam int FRAME_ADDR_LSB = 8;
    localparam int CNT_W = 5;
    // Byte offsets of the lower bytes
    localparam logic [6:0] OFS_FLASH_WRITE_COUNT = 7'h00;
    localparam logic [6:0] OFS_SUPPLY = 7'h02;
    localparam logic [6:0] OFS_RATE = 7'h04;
    localparam logic [6:0] OFS_AUX = 7'h0a;
    localparam logic [6:0] OFS_TEMP = 7'h0c;
    localparam logic [6:0] OFS_ANGLE = 7'h0e;
    localparam logic [6:0] OFS_OFFSET = 7'h14;
    localparam logic [6:0] OFS_SCALE = 7'h16;
    localparam logic [6:0] OFS_ALM1_MAG = 7'h20;
    localparam logic [6:0] OFS_ALM2_MAG = 7'h22;
    localparam logic [6:0] OFS_ALM1_WIN = 7'h24;
    localparam logic [6:0] OFS_ALM2_WIN = 7'h26;
    localparam logic [6:0] OFS_ALARM_CONTROL = 7'h28;
    localparam logic [6:0] OFS_DAC = 7'h30;
    localparam logic [6:0] OFS_GPIO = 7'h32;
    localparam logic [6:0] OFS_MISC = 7'h34;
    localparam logic [6:0] OFS_SMPL = 7'h36;
    localparam logic [6:0] OFS_RANGE = 7'h38;
    localparam logic [6:0] OFS_SLEEP = 7'h3a;
    localparam logic [6:0] OFS_DIAG = 7'h3c;
    localparam logic [6:0] OFS_CMD = 7'h3e;
    localparam logic [6:0] OFS_LOT1 = 7'h52;
    localparam logic [6:0] OFS_LOT2 = 7'h54;
    localparam logic [6:0] OFS_PROD = 7'h56;
    localparam logic [6:0] OFS_SERIAL = 7'h58;
    // Output word layout
    localparam int ND_BIT = 15;
    localparam int EA_BIT = 14;
    localparam int FIELD_W = 14;
    localparam int RATE_W = 14;
    localparam int SUPPLY_W = 12;
    localparam int TEMP_W = 12;
    localparam int AUX_W = 12;
    localparam logic [13:0] ANGLE_MAX = 14'h2663;
    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SCALE = 16'h0800;
    localparam logic [15:0] RST_SMPL = 16'h0001;
    localparam logic [15:0] RST_RANGE = 16'h0402;
    // Range field
    localparam int RANGE_LSB = 8;
    localparam logic [2:0] RANGE_320 = 3'h4;
    localparam logic [2:0] RANGE_160 = 3'h2;
    localparam logic [2:0] RANGE_80 = 3'h1;
    // Command bits
    localparam int CMD_W = 8;
    localparam int CMD_FLASH_UPDATE = 3;
    localparam int CMD_SW_RESET = 7;
    // Nonvolatile read latency in cycles
    localparam logic [1:0] NV_LATENCY = 2'h2;
    typedef enum logic {ST_LOAD, ST_RUN} gur_state_t;
endpackage

// File: verilog/gur_spi_slave.sv
`timescale 1ns/1ns
module gur_spi_slave (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    // Frame side
    input wire logic [15:0] i_tx_word,
    output logic o_frame_valid,
    output logic [15:0] o_frame
);
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic mosi_s1;
        logic mosi_s2;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [gur_pkg::CNT_W-1:0] cnt;
        logic miso;
        logic miso_oe;
        logic frame_valid;
        logic [15:0] frame;
    } gur_spi_t;

    gur_spi_t q;
    gur_spi_t next_q;
    logic rise;
    logic fall;
    logic cs_fall;

    // Edges seen only on the second flop and later
    assign rise = q.sclk_s2 & ~q.sclk_s3;
    assign fall = ~q.sclk_s2 & q.sclk_s3;
    assign cs_fall = ~q.cs_s2 & q.cs_s3;

    // Mode 3: sample on rising, shift out on falling
    always_comb begin
        next_q = q;
        next_q.frame_valid = 1'b0;
        next_q.sclk_s1 = i_sclk;
        next_q.sclk_s2 = q.sclk_s1;
        next_q.sclk_s3 = q.sclk_s2;
        next_q.cs_s1 = i_cs_n;
        next_q.cs_s2 = q.cs_s1;
        next_q.cs_s3 = q.cs_s2;
        next_q.mosi_s1 = i_mosi;
        next_q.mosi_s2 = q.mosi_s1;
        if (cs_fall) begin
            next_q.tx = i_tx_word; // RL19
            next_q.cnt = '0;
            next_q.miso_oe = 1'b1;
        end else if (!q.cs_s2) begin
            if (rise) begin
                next_q.rx = {q.rx[14:0], q.mosi_s2};
                next_q.cnt = q.cnt + 5'h01;
                if (q.cnt == 5'(gur_pkg::FRAME_W - 1)) begin
                    next_q.frame_valid = 1'b1;
                    next_q.frame = {q.rx[14:0], q.mosi_s2};
                end
            end
            if (fall) begin
                next_q.miso = q.tx[15];
                next_q.tx = {q.tx[14:0], 1'b0};
            end
        end else begin
            next_q.miso_oe = 1'b0;
        end
    end

    // Idle pin levels: chip select high, clock high
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.sclk_s1 <= 1'b1;
            q.sclk_s2 <= 1'b1;
            q.sclk_s3 <= 1'b1;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.cs_s3 <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign o_miso = q.miso;
    assign o_miso_oe = q.miso_oe;
    assign o_frame_valid = q.frame_valid;
    assign o_frame = q.frame;
endmodule

// File: bench/gur_register_map_assertions.sv
`timescale 1ns/1ns
// Watches load, link enable and idle stability at the pins
module gur_register_map_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Observed ports
    input wire logic i_cs_n,
    input wire logic o_miso_oe,
    input wire logic o_nv_rd,
    input wire logic [5:0] o_nv_addr,
    input wire logic o_ready,
    input wire logic [7:0] o_command,
    input wire logic [15:0] o_analog_out_setting,
    input wire logic [15:0] o_range_and_filter
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Spans long enough to pass the pin synchronisers
    sequence idle_s;
        i_cs_n [*6];
    endsequence
    sequence busy_s;
        !i_cs_n [*6];
    endsequence
    // Index must hold while the store answers
    sequence nv_hold_s;
        ($stable(o_nv_addr) && !o_nv_rd) [*2];
    endsequence
    ready_after_reset_a: assert property ($past(i_rst) |-> !o_ready)
        else $error("ready high straight after reset");
    load_before_data_a: assert property (o_nv_rd |-> !o_ready)
        else $error("store read while ready");
    nv_index_hold_a: assert property (o_nv_rd |=> nv_hold_s)
        else $error("store index moved during read");
    nv_index_range_a: assert property (o_nv_rd |-> o_nv_addr <= 6'h2c)
        else $error("store index outside the map");
    reload_cmd_a: assert property (o_command[7] |-> ##[0:3] !o_ready)
        else $error("software reset did not drop ready");
    miso_idle_off_a: assert property (idle_s |-> !o_miso_oe)
        else $error("output enabled while deselected");
    miso_busy_on_a: assert property (busy_s |-> o_miso_oe)
        else $error("output not enabled while selected");
    cmd_one_pulse_a: assert property (o_command != 8'h00 |=> o_command == 8'h00)
        else $error("command pulse too long");
    idle_config_a: assert property (idle_s ##0 o_ready [*2] |->
        $stable(o_range_and_filter) && $stable(o_analog_out_setting))
        else $error("configuration changed with link idle");
endmodule

bind gur_register_map gur_register_map_checker u_gur_register_map_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_miso_oe(o_miso_oe), .o_nv_rd(o_nv_rd),
    .o_nv_addr(o_nv_addr), .o_ready(o_ready), .o_command(o_command),
    .o_analog_out_setting(o_analog_out_setting), .o_range_and_filter(o_range_and_filter)
);

// File: bench/gur_host_model.sv
`timescale 1ns/1ns
// Host side master, mode 3, MSB first
module gur_host_model (
    // Serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    // Clock stands high between frames
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // One 16-bit frame, data changes on falling edge
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        o_cs_n = 1'b0;
        #200;
        for (int i = 15; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            #80;
            o_sclk = 1'b1;
            rx[i] = i_miso;
            #80;
        end
        #120;
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // No stale bit once released
        #200;
    endtask
endmodule

// File: bench/gur_register_map_tb.sv
`timescale 1ns/1ns
module gur_register_map_tb;
    localparam logic [15:0] PCODE = 16'h5a5a; // Arbitrary value
    localparam logic [12:0][15:0] CFG_DEF = {16'h0000, 16'h0402, 16'h0001, {8{16'h0000}}, 16'h0800, 16'h0000};
    localparam logic [2:0] RC [3] = '{gur_pkg::RANGE_320, gur_pkg::RANGE_160, gur_pkg::RANGE_80};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sclk, cs_n, mosi, miso, miso_oe, sample_valid, angle_incr, nv_rd, ready;
    logic [11:0] supply, aux, temp;
    logic [13:0] rate;
    logic [15:0] diag, nv_data, rx;
    logic [5:0] nv_addr;
    logic [7:0] command;
    logic [12:0][15:0] cfg;
    logic [7:0] last_cmd = 8'h00;
    int mismatches = 0;
    int n_compared = 0;

    // Core clock
    always #4 i_clk = ~i_clk;

    gur_register_map #(.PRODUCT_CODE(PCODE)) u_gur_register_map (
        .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(miso_oe), .i_sample_valid(sample_valid), .i_supply(supply), .i_rate(rate), .i_aux(aux),
        .i_temp(temp), .i_angle_incr(angle_incr), .i_diag_flags(diag), .o_nv_rd(nv_rd), .o_nv_addr(nv_addr),
        .i_nv_data(nv_data), .o_ready(ready), .o_command(command), .o_rate_offset_trim(cfg[0]),
        .o_rate_scale_trim(cfg[1]), .o_alarm_one_magnitude(cfg[2]), .o_alarm_two_magnitude(cfg[3]),
        .o_alarm_one_rate_window(cfg[4]), .o_alarm_two_rate_window(cfg[5]), .o_alarm_control(cfg[6]),
        .o_analog_out_setting(cfg[7]), .o_digital_line_control(cfg[8]), .o_misc_control(cfg[9]),
        .o_sample_period(cfg[10]), .o_range_and_filter(cfg[11]), .o_sleep_counter(cfg[12])
    );
    // Undriven output line reads inverted, never a lucky match
    gur_host_model u_gur_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_oe ? miso : ~miso));

    // Store image; flash count value is arbitrary
    function automatic logic [15:0] nv_img(input logic [5:0] a);
        case (a)
            6'h00: return 16'h0005;
            6'h0b: return 16'h0800;
            6'h1b: return 16'h0001;
            6'h1c: return 16'h0402;
            default: return 16'h0000;
        endcase
    endfunction
    // Store answers on the edge after the request
    always @(posedge i_clk) nv_data <= nv_img(nv_addr);
    // Command pulse lasts one cycle, so keep the last one for a later compare
    always @(posedge i_clk) begin
        if (command != 8'h00) begin
            last_cmd <= command;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for the load walk to finish
    task automatic wait_ready;
        for (int n = 0; n < 500 && ready !== 1'b1; n++) begin
            @(posedge i_clk);
        end
        if (ready !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t ready never rose", $time);
            close_out();
        end
    endtask
    // One byte per write frame; pins move just after an edge, never on it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        u_gur_host_model.frame({1'b1, a, d}, rx);
    endtask
    // Answer arrives in the following frame
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        #1;
        u_gur_host_model.frame({1'b0, a, 8'h00}, rx);
        u_gur_host_model.frame(16'h0000, rx);
        chk(rx, exp);
    endtask
    // Core pulses, launched just after a rising edge
    task automatic pulse(input logic s, input logic a, input logic [13:0] r, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        sample_valid = s;
        angle_incr = a;
        rate = r;
        diag = d;
        @(posedge i_clk);
        #1;
        sample_valid = 1'b0;
        angle_incr = 1'b0;
    endtask

    initial begin
        sample_valid = 1'b0;
        angle_incr = 1'b0;
        supply = 12'haaa;
        aux = 12'hfff;
        temp = 12'h227;
        rate = 14'h0000;
        diag = 16'h0000;
        nv_data = 16'h0000;
        repeat (4) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        wait_ready();
        for (int i = 0; i < 13; i++) begin
            chk(cfg[i], CFG_DEF[i]);
        end
        rd(7'h01, 16'h0005);
        rd(7'h56, PCODE);
        rd(7'h06, 16'h0000);
        rd(7'h3e, 16'h0000);
        wr(7'h30, 8'h34);
        wr(7'h31, 8'h12);
        chk(cfg[7], 16'h1234);
        rd(7'h31, 16'h1234);
        wr(7'h0c, 8'h55);
        pulse(1'b1, 1'b0, 14'h3fff, 16'h0000);
        rd(7'h04, 16'hbfff);
        rd(7'h05, 16'h3fff);
        rd(7'h02, 16'h8aaa);
        rd(7'h0a, 16'h8fff);
        rd(7'h0d, 16'h8227);
        pulse(1'b0, 1'b0, 14'h3fff, 16'h0004);
        rd(7'h02, 16'h4aaa);
        for (int k = 0; k < 3; k++) begin
            wr(7'h39, {5'h00, RC[k]});
            pulse(1'b1, 1'b0, 14'h0001, 16'h0000);
            rd(7'h04, 16'h8000 | (16'h0001 << k));
        end
        wr(7'h0e, 8'h62);
        wr(7'h0f, 8'h26);
        pulse(1'b0, 1'b1, 14'h0001, 16'h0000);
        rd(7'h0e, 16'ha663);
        pulse(1'b0, 1'b1, 14'h0001, 16'h0000);
        rd(7'h0f, 16'h8000);
        wr(7'h3e, 8'h08);
        chk({8'h00, last_cmd}, 16'h0008);
        rd(7'h00, 16'h0006);
        wr(7'h3e, 8'h80);
        wait_ready();
        chk({8'h00, last_cmd}, 16'h0080);
        chk(cfg[7], 16'h0000);
        chk(cfg[11], 16'h0402);
        close_out();
    end
endmodule
